// ---- logic/autoreload_timer16_core.sv ----
// Notes on behaviour
// - Counter clocks from internal clock via prescaler dividing by 1, 4 or 16.
// - Run bit low keeps the counter stopped and at zero.
// - Underflow without reload loads all ones, free running.
// - Underflow with reload enabled loads the reload/capture register.
// - Each zero-to-reload transition sets the overflow flag.
// - With reload enabled, the capture input event selected as start source reloads the counter.
// - Masked counter compared in the cycle after each count with masked compare value and zero.
// - Masked zero match sets zero flag; compare match sets compare flag.
// - Selected second-input event copies the counter into the capture register.
// - Reload register is a capture target only with reload disabled.
// - Reload disabled: both events capture while the counter runs free.
// - Reload enabled: first event reloads and starts, later event captures.
// - Two select bits choose software, first or second input start.
// - Polarity-selected second input event strobes capture into capture reg.
// - Set/reset PWM: zero match drives pin to polarity value.
// - Set/reset PWM: compare match drives pin to inverted polarity.
// - Toggle PWM inverts the pin at each masked compare match.
// - Overflow set mode raises output; only flag clear lowers it.
// - Overflow toggle mode inverts output on each overflow.
// - Zero mask matches on every prescaled count.
// - Divide select zero stops prescaler and counter; others pick 1,4,16.
// - Run bit enables counting and the capture input edge detectors.
// - Overflow flag is set only by hardware; software may only clear.
// - Interrupt is the OR of each event flag ANDed with its enable.
//
// The register offsets and strobed register access were left to the implementer.
module autoreload_timer16_core (
	input  wire logic        clk,         // 100 MHz clock
	input  wire logic        rstn,        // Async reset, active low
	input  wire logic [3:0]  addr,        // Register word index
	input  wire logic [15:0] wdata,       // Write data
	input  wire logic        wr,          // Write strobe
	input  wire logic        rd,          // Read strobe
	output logic      [15:0] rdata,       // Read data, cycle after rd
	input  wire logic        capture_input_a, // First capture input
	input  wire logic        capture_input_b, // Second capture input
	output logic             pwm_out,     // PWM pin
	output logic             overflow_output_pin, // Overflow pin
	output logic             irq          // Timer interrupt
);

	// ************************************************************
	// Reset release
	// ************************************************************
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	logic [15:0] ctrl_r;
	logic [15:0] cfg_r;
	logic [15:0] compare_value_reg;
	logic [15:0] mask_r;
	logic [15:0] reload_capture_reg;
	logic [15:0] capture_reg;
	logic [15:0] down_counter;
	logic [timer_pkg::FLG_W-1:0] flags_r;
	logic        run_control_bit;
	logic        reload_en;
	logic        clock_divide_sel_hi;
	logic        clock_divide_sel_lo;
	logic        pwm_output_enable;
	logic        pwm_toggle_sel;
	logic        pwm_polarity;
	logic        overflow_out_toggle_sel;
	logic [1:0]  start_src;
	logic        wr_ctrl;

	assign run_control_bit = ctrl_r[timer_pkg::CTRL_RUN];
	assign reload_en       = ctrl_r[timer_pkg::CTRL_RELOAD_EN];
	assign clock_divide_sel_hi = ctrl_r[timer_pkg::CTRL_DIV_HI];
	assign clock_divide_sel_lo = ctrl_r[timer_pkg::CTRL_DIV_LO];
	assign overflow_out_toggle_sel = ctrl_r[timer_pkg::CTRL_OVF_TOGGLE];
	assign pwm_output_enable = cfg_r[timer_pkg::CFG_PWM_EN];
	assign pwm_toggle_sel    = cfg_r[timer_pkg::CFG_PWM_TOGGLE];
	assign pwm_polarity      = cfg_r[timer_pkg::CFG_PWM_POL];
	assign start_src = {cfg_r[timer_pkg::CFG_SRC_HI],
		cfg_r[timer_pkg::CFG_SRC_LO]};
	assign wr_ctrl = wr && (addr == timer_pkg::ADDR_CTRL);

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			ctrl_r            <= timer_pkg::CTRL_RST;
			cfg_r             <= timer_pkg::CFG_RST;
			compare_value_reg <= timer_pkg::WORD_RST;
			mask_r            <= timer_pkg::WORD_RST;
		end
		else if (wr)
		begin
			if (addr == timer_pkg::ADDR_CTRL)
				ctrl_r <= {8'h00, wdata[7:1], 1'b0};
			else if (addr == timer_pkg::ADDR_CFG)
				cfg_r <= {3'h0, wdata[12:8], 1'b0, wdata[6:0]};
			else if (addr == timer_pkg::ADDR_COMPARE)
				compare_value_reg <= wdata;
			else if (addr == timer_pkg::ADDR_MASK)
				mask_r <= wdata;
		end
	end

	// ************************************************************
	// Capture inputs
	// ************************************************************
	logic prev_a_r;
	logic prev_b_r;
	logic ev_a;
	logic ev_b;
	logic run_prev_r;
	logic run_rise;

	// edge history held idle while stopped
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			prev_a_r   <= 1'b0;
			prev_b_r   <= 1'b0;
			run_prev_r <= 1'b0;
		end
		else
		begin
			prev_a_r   <= run_control_bit && capture_input_a;
			prev_b_r   <= run_control_bit && capture_input_b;
			run_prev_r <= run_control_bit;
		end
	end

	assign ev_a = run_control_bit && run_prev_r &&
		(cfg_r[timer_pkg::CFG_POL_A] ? (capture_input_a && !prev_a_r)
		: (!capture_input_a && prev_a_r));
	assign ev_b = run_control_bit && run_prev_r &&
		(cfg_r[timer_pkg::CFG_POL_B] ? (capture_input_b && !prev_b_r)
		: (!capture_input_b && prev_b_r));
	assign run_rise = run_control_bit && !run_prev_r;

	// ************************************************************
	// Prescaler
	// ************************************************************
	logic [3:0] presc_r;
	logic [3:0] presc_last;
	logic       tick;

	always_comb
	begin
		case ({clock_divide_sel_hi, clock_divide_sel_lo})
			2'b01:   presc_last = timer_pkg::DIV1_LAST;
			2'b10:   presc_last = timer_pkg::DIV4_LAST;
			default: presc_last = timer_pkg::DIV16_LAST;
		endcase
	end

	// divide by 1, 4 or 16
	assign tick = run_control_bit && (presc_r == presc_last) &&
		(clock_divide_sel_hi || clock_divide_sel_lo);

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			presc_r <= 4'h0;
		else if (!run_control_bit || wr_ctrl || tick ||
			!(clock_divide_sel_hi || clock_divide_sel_lo))
			presc_r <= 4'h0;
		else
			presc_r <= presc_r + 4'h1;
	end

	// ************************************************************
	// Down counter
	// ************************************************************
	logic started_r;
	logic start_evt;
	logic underflow;
	logic counting;
	logic upd_r;

	always_comb
	begin
		case (start_src)
			2'b00:   start_evt = run_rise;
			2'b01:   start_evt = ev_a;
			default: start_evt = ev_b;
		endcase
	end

	assign counting  = !reload_en || started_r;
	assign underflow = tick && counting && (down_counter == 16'h0000);

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			started_r <= 1'b0;
		else if (!run_control_bit)
			started_r <= 1'b0;
		else if (reload_en && start_evt)
			started_r <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			down_counter <= timer_pkg::WORD_RST;
			upd_r        <= 1'b0;
		end
		else
		begin
			upd_r <= run_control_bit && tick && counting;
			if (!run_control_bit)
				down_counter <= timer_pkg::WORD_RST;
			else if (reload_en && start_evt)
				down_counter <= reload_capture_reg;
			else if (underflow && reload_en)
				down_counter <= reload_capture_reg;
			else if (underflow)
				down_counter <= timer_pkg::FREE_RELOAD;
			else if (tick && counting)
				down_counter <= down_counter - 16'h0001;
		end
	end

	// ************************************************************
	// Captures
	// ************************************************************
	// second input captures counter
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			capture_reg <= timer_pkg::WORD_RST;
		else if (ev_b && !(reload_en && start_evt && !started_r))
			capture_reg <= down_counter;
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			reload_capture_reg <= timer_pkg::WORD_RST;
		else if (!reload_en && ev_a)
			reload_capture_reg <= down_counter;
		else if (wr && addr == timer_pkg::ADDR_RELOAD)
			reload_capture_reg <= wdata;
	end

	// ************************************************************
	// Compare and flags
	// ************************************************************
	logic zero_hit;
	logic cmp_hit;
	logic [timer_pkg::FLG_W-1:0] flag_set;
	logic [timer_pkg::FLG_W-1:0] flag_clr;

	assign zero_hit = upd_r && ((down_counter & mask_r) == 16'h0000);
	assign cmp_hit  = upd_r &&
		((down_counter & mask_r) == (compare_value_reg & mask_r));

	assign flag_set = {ev_b, ev_a, cmp_hit, zero_hit, underflow};
	assign flag_clr = (wr && addr == timer_pkg::ADDR_FLAGS) ?
		wdata[timer_pkg::FLG_W-1:0] : {timer_pkg::FLG_W{1'b0}};

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			flags_r <= {timer_pkg::FLG_W{1'b0}};
		else
			flags_r <= (flags_r & ~flag_clr) | flag_set;
	end

	// ************************************************************
	// Output pins
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			pwm_out <= 1'b0;
		else if (!pwm_output_enable)
			pwm_out <= pwm_polarity;
		else if (pwm_toggle_sel)
		begin
			if (cmp_hit)
				pwm_out <= !pwm_out;
		end
		// compare ends the pulse, it wins a tie
		else if (cmp_hit)
			pwm_out <= !pwm_polarity;
		else if (zero_hit)
			pwm_out <= pwm_polarity;
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			overflow_output_pin <= 1'b0;
		else if (overflow_out_toggle_sel)
		begin
			if (underflow)
				overflow_output_pin <= !overflow_output_pin;
		end
		// follows the flag, so only a clear lowers it
		else
			overflow_output_pin <= underflow ||
				(flags_r[timer_pkg::FLG_OVF] &&
				!flag_clr[timer_pkg::FLG_OVF]);
	end

	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			irq <= 1'b0;
		else
			irq <= |(flags_r &
				cfg_r[timer_pkg::CFG_IEN_LSB +: timer_pkg::FLG_W]);
	end

	// ************************************************************
	// Read port
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
			rdata <= 16'h0000;
		else if (!rd)
			rdata <= 16'h0000;
		else if (addr == timer_pkg::ADDR_CTRL)
			rdata <= ctrl_r;
		else if (addr == timer_pkg::ADDR_FLAGS)
			rdata <= {11'h000, flags_r};
		else if (addr == timer_pkg::ADDR_CFG)
			rdata <= cfg_r;
		else if (addr == timer_pkg::ADDR_RELOAD)
			rdata <= reload_capture_reg;
		else if (addr == timer_pkg::ADDR_CAPTURE)
			rdata <= capture_reg;
		else if (addr == timer_pkg::ADDR_COMPARE)
			rdata <= compare_value_reg;
		else if (addr == timer_pkg::ADDR_MASK)
			rdata <= mask_r;
		else if (addr == timer_pkg::ADDR_COUNTER)
			rdata <= down_counter;
		else
			rdata <= 16'h0000;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	property p_stop_zero;
		@(posedge clk) disable iff (!rst_n_r)
		!$past(run_control_bit) |-> down_counter == 16'h0000;
	endproperty
	a_stop_zero: assert property (p_stop_zero)
		else $error("counter not zero while stopped");

	property p_free_reload;
		@(posedge clk) disable iff (!rst_n_r)
		(underflow && !reload_en && !start_evt) |=>
			down_counter == 16'hffff;
	endproperty
	a_free_reload: assert property (p_free_reload)
		else $error("free running reload not all ones");

	property p_reg_reload;
		@(posedge clk) disable iff (!rst_n_r)
		(underflow && reload_en) |=>
			down_counter == $past(reload_capture_reg);
	endproperty
	a_reg_reload: assert property (p_reg_reload)
		else $error("underflow did not reload register value");

	property p_ovf_flag;
		@(posedge clk) disable iff (!rst_n_r)
		underflow |=> flags_r[timer_pkg::FLG_OVF];
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow flag not set");

	property p_no_sw_set;
		@(posedge clk) disable iff (!rst_n_r)
		(!flags_r[timer_pkg::FLG_OVF] && !underflow) |=>
			!flags_r[timer_pkg::FLG_OVF];
	endproperty
	a_no_sw_set: assert property (p_no_sw_set)
		else $error("overflow flag set without overflow");

	property p_capture;
		@(posedge clk) disable iff (!rst_n_r)
		(ev_b && started_r) |=> capture_reg == $past(down_counter);
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture register missed counter value");

	property p_reload_kept;
		@(posedge clk) disable iff (!rst_n_r)
		(reload_en && !wr) |=> $stable(reload_capture_reg);
	endproperty
	a_reload_kept: assert property (p_reload_kept)
		else $error("reload value overwritten by capture");

	property p_pwm_idle;
		@(posedge clk) disable iff (!rst_n_r)
		!pwm_output_enable |=> pwm_out == $past(pwm_polarity);
	endproperty
	a_pwm_idle: assert property (p_pwm_idle)
		else $error("disabled pwm pin not at polarity");

	property p_pwm_toggle;
		@(posedge clk) disable iff (!rst_n_r)
		(pwm_output_enable && pwm_toggle_sel && cmp_hit) |=>
			pwm_out != $past(pwm_out);
	endproperty
	a_pwm_toggle: assert property (p_pwm_toggle)
		else $error("pwm did not toggle on compare");

	property p_ovf_toggle;
		@(posedge clk) disable iff (!rst_n_r)
		(overflow_out_toggle_sel && underflow) |=>
			overflow_output_pin != $past(overflow_output_pin);
	endproperty
	a_ovf_toggle: assert property (p_ovf_toggle)
		else $error("overflow pin did not toggle");

	property p_div16;
		@(posedge clk) disable iff (!rst_n_r)
		(tick && clock_divide_sel_hi && clock_divide_sel_lo && !wr) |=>
			!tick [*8];
	endproperty
	a_div16: assert property (p_div16)
		else $error("divide by sixteen tick too early");

endmodule : autoreload_timer16_core

// ---- logic/timer_pkg.sv ----
package timer_pkg;

	// ************************************************************
	// Register word indices on the plain register port
	// ************************************************************
	localparam logic [3:0] ADDR_CTRL    = 4'h0;
	localparam logic [3:0] ADDR_FLAGS   = 4'h1;
	localparam logic [3:0] ADDR_CFG     = 4'h2;
	localparam logic [3:0] ADDR_RELOAD  = 4'h3;
	localparam logic [3:0] ADDR_CAPTURE = 4'h4;
	localparam logic [3:0] ADDR_COMPARE = 4'h5;
	localparam logic [3:0] ADDR_MASK    = 4'h6;
	localparam logic [3:0] ADDR_COUNTER = 4'h7;

	// ************************************************************
	// Field positions
	// ************************************************************
	// Control word
	localparam int CTRL_DIV_LO     = 6;
	localparam int CTRL_DIV_HI     = 7;
	localparam int CTRL_RELOAD_EN  = 5;
	localparam int CTRL_RUN        = 4;
	localparam int CTRL_OVF_TOGGLE = 1;
	// Flag word, write one to clear
	localparam int FLG_OVF   = 0;
	localparam int FLG_ZERO  = 1;
	localparam int FLG_CMP   = 2;
	localparam int FLG_CAP_A = 3;
	localparam int FLG_CAP_B = 4;
	localparam int FLG_W     = 5;
	// Configuration word
	localparam int CFG_PWM_EN     = 0;
	localparam int CFG_PWM_TOGGLE = 1;
	localparam int CFG_PWM_POL    = 2;
	localparam int CFG_POL_A      = 3;
	localparam int CFG_POL_B      = 4;
	localparam int CFG_SRC_LO     = 5;
	localparam int CFG_SRC_HI     = 6;
	localparam int CFG_IEN_LSB    = 8;

	// ************************************************************
	// Values and counts
	// ************************************************************
	localparam logic [15:0] CTRL_RST    = 16'h0000;
	localparam logic [15:0] CFG_RST     = 16'h0000;
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [15:0] FREE_RELOAD = 16'hffff;
	localparam logic [3:0]  DIV1_LAST   = 4'h0;
	localparam logic [3:0]  DIV4_LAST   = 4'h3;
	localparam logic [3:0]  DIV16_LAST  = 4'hf;

endpackage : timer_pkg

// ---- verif/capture_source.sv ----
module capture_source (
	input  wire logic clk,             // Bench clock
	input  wire logic slow,            // Add one cycle of lag
	input  wire logic lvl_a,           // Wanted level, first input
	input  wire logic lvl_b,           // Wanted level, second input
	output logic      capture_input_a, // First capture pin
	output logic      capture_input_b  // Second capture pin
);
	timeunit 1ns;
	timeprecision 100ps;

	logic a_d;
	logic b_d;

	// ************************************************************
	// Pin drivers
	// ************************************************************
	// Pins move only just after an edge, like a synchronous source
	initial
	begin
		a_d = 1'b0;
		b_d = 1'b0;
		capture_input_a = 1'b0;
		capture_input_b = 1'b0;
	end

	always @(posedge clk)
	begin
		a_d <= lvl_a;
		b_d <= lvl_b;
		capture_input_a <= slow ? a_d : lvl_a;
		capture_input_b <= slow ? b_d : lvl_b;
	end
endmodule : capture_source

// ---- verif/test_autoreload_timer16_core.sv ----
module test_autoreload_timer16_core;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk;
	logic        rstn;
	logic [3:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        slow;
	logic        lvl_a;
	logic        lvl_b;
	logic        cap_a;
	logic        cap_b;
	logic        pwm_out;
	logic        ovf_pin;
	logic        irq;
	logic [15:0] v0;
	logic [15:0] v1;
	logic [15:0] v2;
	logic        p0;
	int          miscompares;
	int          tests_run;
	int          cycles = 0;
	int          rl;
	int          cv;
	int          hi;
	int          div_of[4] = '{0, 1, 4, 16};

	capture_source far_end (
		.clk             (clk),
		.slow            (slow),
		.lvl_a           (lvl_a),
		.lvl_b           (lvl_b),
		.capture_input_a (cap_a),
		.capture_input_b (cap_b)
	);

	autoreload_timer16_core DUT (
		.clk                 (clk),
		.rstn                (rstn),
		.addr                (addr),
		.wdata               (wdata),
		.wr                  (wr),
		.rd                  (rd),
		.rdata               (rdata),
		.capture_input_a     (cap_a),
		.capture_input_b     (cap_b),
		.pwm_out             (pwm_out),
		.overflow_output_pin (ovf_pin),
		.irq                 (irq)
	);

	// ************************************************************
	// Clock, watchdog and shared tasks
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Whole run needs under 700 cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			miscompares = miscompares + 1;
			close_out();
		end
	end

	task close_out;
		$display("Compares %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask : rd_reg

	// Counter drop between two reads taken g edges apart
	task cnt_gap(input int g, output logic [15:0] d);
		rd_reg(timer_pkg::ADDR_COUNTER, v1);
		repeat (g - 2) @(posedge clk);
		rd_reg(timer_pkg::ADDR_COUNTER, v2);
		d = v1 - v2;
	endtask : cnt_gap

	task hi_count(input int n, output int h);
		h = 0;
		repeat (n)
		begin
			@(negedge clk);
			h = h + int'(pwm_out);
		end
	endtask : hi_count

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		rstn = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		slow = 1'b0;
		lvl_a = 1'b0;
		lvl_b = 1'b0;
		miscompares = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		cv = $urandom(32'h67c2);
		rl = $urandom_range(40, 16);
		cv = $urandom_range(rl - 2, 2);
		rd_reg(timer_pkg::ADDR_CTRL, v0);
		chk(v0, timer_pkg::CTRL_RST);
		chk(pwm_out, 16'h0000);
		wr_reg(timer_pkg::ADDR_COUNTER, 16'h1234);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0, 16'h0000);
		rd_reg(4'hc, v0);
		chk(v0, 16'h0000);
		for (int c = 0; c < 4; c++)
		begin
			wr_reg(timer_pkg::ADDR_CTRL, 16'(c << 6) | 16'h0010);
			cnt_gap(32, v0);
			chk(v0, 16'(c == 0 ? 0 : 32 / div_of[c]));
		end
		rd_reg(timer_pkg::ADDR_FLAGS, v0);
		chk(v0 & 16'h0001, 16'h0001);
		chk(ovf_pin, 16'h0001);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0 >= 16'hff00, 16'h0001);
		wr_reg(timer_pkg::ADDR_FLAGS, 16'h001f);
		rd_reg(timer_pkg::ADDR_FLAGS, v0);
		chk(v0 & 16'h0001, 16'h0000);
		chk(ovf_pin, 16'h0000);
		wr_reg(timer_pkg::ADDR_RELOAD, 16'(rl));
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0072);
		cnt_gap(rl + 1, v0);
		chk(v0, 16'h0000);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0 <= rl, 16'h0001);
		rd_reg(timer_pkg::ADDR_RELOAD, v0);
		chk(v0, 16'(rl));
		@(negedge clk);
		p0 = ovf_pin;
		repeat (rl + 1) @(negedge clk);
		chk(ovf_pin, !p0);
		wr_reg(timer_pkg::ADDR_MASK, 16'hffff);
		wr_reg(timer_pkg::ADDR_COMPARE, 16'(cv));
		for (int pol = 0; pol < 2; pol++)
		begin
			wr_reg(timer_pkg::ADDR_CFG, 16'(pol << 2));
			repeat (2) @(posedge clk);
			chk(pwm_out, 16'(pol));
			wr_reg(timer_pkg::ADDR_CFG, 16'(pol << 2) | 16'h0001);
			repeat (rl + 1) @(negedge clk);
			hi_count(rl + 1, hi);
			chk(16'(hi), 16'(pol == 1 ? rl - cv + 1 : cv));
		end
		wr_reg(timer_pkg::ADDR_CFG, 16'h0003);
		@(negedge clk);
		p0 = pwm_out;
		repeat (rl + 1) @(negedge clk);
		chk(pwm_out, !p0);
		wr_reg(timer_pkg::ADDR_MASK, 16'h0000);
		wr_reg(timer_pkg::ADDR_FLAGS, 16'h001f);
		@(negedge clk);
		p0 = pwm_out;
		repeat (6)
		begin
			@(negedge clk);
			chk(pwm_out, !p0);
			p0 = pwm_out;
		end
		rd_reg(timer_pkg::ADDR_FLAGS, v0);
		chk(v0 & 16'h0006, 16'h0006);
		wr_reg(timer_pkg::ADDR_CFG, 16'h0200);
		repeat (4) @(posedge clk);
		chk(irq, 16'h0001);
		wr_reg(timer_pkg::ADDR_CFG, 16'h0800);
		repeat (3) @(posedge clk);
		chk(irq, 16'h0000);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0050);
		wr_reg(timer_pkg::ADDR_CFG, 16'h0018);
		wr_reg(timer_pkg::ADDR_FLAGS, 16'h001f);
		@(posedge clk);
		lvl_a <= 1'b1;
		lvl_b <= 1'b1;
		repeat (6) @(posedge clk);
		rd_reg(timer_pkg::ADDR_RELOAD, v0);
		rd_reg(timer_pkg::ADDR_CAPTURE, v2);
		chk(v2, v0);
		rd_reg(timer_pkg::ADDR_COUNTER, v1);
		chk(v0 - v1 < 16'd24 && v0 != v1, 16'h0001);
		rd_reg(timer_pkg::ADDR_FLAGS, v2);
		chk(v2 & 16'h0018, 16'h0018);
		// start from the first input, lagging source
		lvl_a <= 1'b0;
		lvl_b <= 1'b0;
		slow <= 1'b1;
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(timer_pkg::ADDR_RELOAD, 16'(rl));
		wr_reg(timer_pkg::ADDR_CFG, 16'h0028);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0070);
		cnt_gap(12, v0);
		chk(v0, 16'h0000);
		@(posedge clk);
		lvl_a <= 1'b1;
		repeat (5) @(posedge clk);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0 <= rl && v0 + 12 >= rl, 16'h0001);
		rd_reg(timer_pkg::ADDR_RELOAD, v0);
		chk(v0, 16'(rl));
		// start and capture from the second input
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(timer_pkg::ADDR_CFG, 16'h0050);
		wr_reg(timer_pkg::ADDR_FLAGS, 16'h001f);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0070);
		@(posedge clk);
		lvl_b <= 1'b1;
		repeat (5) @(posedge clk);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0 <= rl && v0 + 12 >= rl, 16'h0001);
		lvl_b <= 1'b0;
		repeat (8) @(posedge clk);
		lvl_b <= 1'b1;
		repeat (5) @(posedge clk);
		rd_reg(timer_pkg::ADDR_CAPTURE, v2);
		chk(v2 <= rl, 16'h0001);
		rd_reg(timer_pkg::ADDR_FLAGS, v2);
		chk(v2 & 16'h0010, 16'h0010);
		// falling polarity on the second input
		wr_reg(timer_pkg::ADDR_CFG, 16'h0040);
		wr_reg(timer_pkg::ADDR_FLAGS, 16'h001f);
		rd_reg(timer_pkg::ADDR_FLAGS, v2);
		chk(v2 & 16'h0010, 16'h0000);
		lvl_b <= 1'b0;
		repeat (5) @(posedge clk);
		rd_reg(timer_pkg::ADDR_FLAGS, v2);
		chk(v2 & 16'h0010, 16'h0010);
		wr_reg(timer_pkg::ADDR_CTRL, 16'h0000);
		rd_reg(timer_pkg::ADDR_COUNTER, v0);
		chk(v0, 16'h0000);
		close_out();
	end
endmodule : test_autoreload_timer16_core
